// ---- rtl/dpw_top.sv ----
/*
  Dual 10-bit PWM with per-channel period-timer selection and registers.
  Assumes three period timers on mclk supply count, increment, match and
  prescale; pin routing and direction control live outside.
*/
// Our own choices: the strobed register port and the register offsets.
`default_nettype none
module dpw_top (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // Register port
  input  wire logic [2:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  // Period timers: index 0 two, 1 four, 2 six
  input  wire dpw_pkg::dpw_tmr_type tmr_two,
  input  wire dpw_pkg::dpw_tmr_type tmr_four,
  input  wire dpw_pkg::dpw_tmr_type tmr_six,
  // Channel outputs
  output logic                      chan_a_out,
  output logic                      chan_b_out
);
  logic [1:0] chan_a_timebase_sel_r;
  logic [1:0] chan_b_timebase_sel_r;
  logic       chan_a_enable_r;
  logic       chan_a_polarity_r;
  logic       chan_b_enable_r;
  logic       chan_b_polarity_r;
  logic [7:0] a_dch_r;
  logic [1:0] a_dcl_r;
  logic [7:0] b_dch_r;
  logic [1:0] b_dcl_r;
  logic [1:0] clk_phase_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_tsel  = reg_wr & (reg_addr == dpw_pkg::ADDR_TSEL);
  wire wr_a_con = reg_wr & (reg_addr == dpw_pkg::ADDR_A_CON);
  wire wr_a_dch = reg_wr & (reg_addr == dpw_pkg::ADDR_A_DCH);
  wire wr_a_dcl = reg_wr & (reg_addr == dpw_pkg::ADDR_A_DCL);
  wire wr_b_con = reg_wr & (reg_addr == dpw_pkg::ADDR_B_CON);
  wire wr_b_dch = reg_wr & (reg_addr == dpw_pkg::ADDR_B_DCH);
  wire wr_b_dcl = reg_wr & (reg_addr == dpw_pkg::ADDR_B_DCL);

  ////////////////////////////////////////////////////////////////////////
  // Registers; only implemented bits are stored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chan_a_timebase_sel_r <= dpw_pkg::TSEL_RST;
      chan_b_timebase_sel_r <= dpw_pkg::TSEL_RST;
    end else if (wr_tsel) begin
      chan_a_timebase_sel_r <= reg_wdata[dpw_pkg::TSEL_A_POS +: 2];
      chan_b_timebase_sel_r <= reg_wdata[dpw_pkg::TSEL_B_POS +: 2];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chan_a_enable_r   <= 1'b0;
      chan_a_polarity_r <= 1'b0;
      chan_b_enable_r   <= 1'b0;
      chan_b_polarity_r <= 1'b0;
    end else begin
      if (wr_a_con) begin
        chan_a_enable_r   <= reg_wdata[dpw_pkg::CON_EN_BIT];
        chan_a_polarity_r <= reg_wdata[dpw_pkg::CON_POL_BIT];
      end
      if (wr_b_con) begin
        chan_b_enable_r   <= reg_wdata[dpw_pkg::CON_EN_BIT];
        chan_b_polarity_r <= reg_wdata[dpw_pkg::CON_POL_BIT];
      end
    end
  end

  // Duty is unknown/unchanged at reset in the part; zero here for determinism
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      a_dch_r <= dpw_pkg::ZERO8;
      a_dcl_r <= 2'h0;
      b_dch_r <= dpw_pkg::ZERO8;
      b_dcl_r <= 2'h0;
    end else begin
      if (wr_a_dch) a_dch_r <= reg_wdata;
      if (wr_a_dcl) a_dcl_r <= reg_wdata[dpw_pkg::DCL_LSB_POS +: 2];
      if (wr_b_dch) b_dch_r <= reg_wdata;
      if (wr_b_dcl) b_dcl_r <= reg_wdata[dpw_pkg::DCL_LSB_POS +: 2];
    end
  end

  // Free-running clock phase gives the low time-base bits at prescale 1
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) clk_phase_r <= 2'h0;
    else       clk_phase_r <= clk_phase_r + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer selection; reserved code gives an idle time base
  function automatic dpw_pkg::dpw_tmr_type pick(input logic [1:0] sel,
      input dpw_pkg::dpw_tmr_type t2, input dpw_pkg::dpw_tmr_type t4,
      input dpw_pkg::dpw_tmr_type t6);
    dpw_pkg::dpw_tmr_type r;
    r = '0;
    case (sel)
      dpw_pkg::TSEL_TWO:  r = t2;
      dpw_pkg::TSEL_FOUR: r = t4;
      dpw_pkg::TSEL_SIX:  r = t6;
      default:            r = '0;
    endcase
    return r;
  endfunction

  wire dpw_pkg::dpw_tmr_type tmr_a =
    pick(chan_a_timebase_sel_r, tmr_two, tmr_four, tmr_six);
  wire dpw_pkg::dpw_tmr_type tmr_b =
    pick(chan_b_timebase_sel_r, tmr_two, tmr_four, tmr_six);

  wire dpw_pkg::dpw_chan_cfg_type cfg_a =
    '{enable: chan_a_enable_r, polarity: chan_a_polarity_r, duty: {a_dch_r, a_dcl_r}};
  wire dpw_pkg::dpw_chan_cfg_type cfg_b =
    '{enable: chan_b_enable_r, polarity: chan_b_polarity_r, duty: {b_dch_r, b_dcl_r}};

  dpw_channel u_chan_a (
    .mclk      (mclk),
    .rstn      (rstn),
    .cfg       (cfg_a),
    .tmr       (tmr_a),
    .clk_phase (clk_phase_r),
    .pwm_out   (chan_a_out)
  );

  dpw_channel u_chan_b (
    .mclk      (mclk),
    .rstn      (rstn),
    .cfg       (cfg_b),
    .tmr       (tmr_b),
    .clk_phase (clk_phase_r),
    .pwm_out   (chan_b_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read mux; level readback shows the live channel output
  wire chan_a_level_readback = chan_a_out;
  wire chan_b_level_readback = chan_b_out;
  wire [7:0] con_a = {chan_a_enable_r, 1'b0, chan_a_level_readback, chan_a_polarity_r, 4'h0};
  wire [7:0] con_b = {chan_b_enable_r, 1'b0, chan_b_level_readback, chan_b_polarity_r, 4'h0};

  always_comb begin
    case (reg_addr)
      dpw_pkg::ADDR_TSEL:  rdata_nxt = {4'h0, chan_b_timebase_sel_r, chan_a_timebase_sel_r};
      dpw_pkg::ADDR_A_CON: rdata_nxt = con_a;
      dpw_pkg::ADDR_A_DCH: rdata_nxt = a_dch_r;
      dpw_pkg::ADDR_A_DCL: rdata_nxt = {a_dcl_r, 6'h00};
      dpw_pkg::ADDR_B_CON: rdata_nxt = con_b;
      dpw_pkg::ADDR_B_DCH: rdata_nxt = b_dch_r;
      dpw_pkg::ADDR_B_DCL: rdata_nxt = {b_dcl_r, 6'h00};
      default:             rdata_nxt = dpw_pkg::ZERO8;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)       rdata_r <= dpw_pkg::ZERO8;
    else if (reg_rd) rdata_r <= rdata_nxt;
    else             rdata_r <= dpw_pkg::ZERO8;
  end

  assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// ---- rtl/dpw_pkg.sv ----
/*
  Package for the dual PWM block: register indices, field positions,
  reset values, timer-select codes and the timer-input carrier.
  Assumes the shared period timers sit outside and feed count/match/prescale.
*/
`default_nettype none
package dpw_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_TSEL   = 3'h0;
  localparam logic [2:0] ADDR_A_CON  = 3'h1;
  localparam logic [2:0] ADDR_A_DCH  = 3'h2;
  localparam logic [2:0] ADDR_A_DCL  = 3'h3;
  localparam logic [2:0] ADDR_B_CON  = 3'h4;
  localparam logic [2:0] ADDR_B_DCH  = 3'h5;
  localparam logic [2:0] ADDR_B_DCL  = 3'h6;
  // Field positions
  localparam int CON_EN_BIT  = 7;
  localparam int CON_OUT_BIT = 5;
  localparam int CON_POL_BIT = 4;
  localparam int DCL_LSB_POS = 6;
  localparam int TSEL_A_POS  = 0;
  localparam int TSEL_B_POS  = 2;
  // Timer-select codes
  localparam logic [1:0] TSEL_RSVD = 2'h0;
  localparam logic [1:0] TSEL_TWO  = 2'h1;
  localparam logic [1:0] TSEL_FOUR = 2'h2;
  localparam logic [1:0] TSEL_SIX  = 2'h3;
  localparam logic [1:0] TSEL_RST  = TSEL_TWO;
  // Prescale codes of a period timer (factor 1, 4, 16)
  localparam logic [1:0] PRE_1  = 2'h0;
  localparam logic [1:0] PRE_4  = 2'h1;
  localparam logic [1:0] PRE_16 = 2'h2;
  localparam logic [9:0] DUTY_RST = 10'h000;
  localparam logic [7:0] ZERO8    = 8'h00;
  localparam int NUM_TMR = 3;

  // One shared period timer as seen by the PWM
  typedef struct packed {
    logic [7:0] count;     // Timer value
    logic       inc;       // One-cycle pulse: timer increments this cycle
    logic       match;     // Level: count equals period value
    logic [1:0] prescale;  // Prescale code
    logic [3:0] pre_cnt;   // Prescaler counter bits
  } dpw_tmr_type;

  typedef struct packed {
    logic       enable;
    logic       polarity;
    logic [9:0] duty;
  } dpw_chan_cfg_type;
endpackage
`default_nettype wire

// ---- rtl/dpw_channel.sv ----
/*
  One PWM channel: duty double buffer, 10-bit comparator, output polarity.
  Assumes the selected timer struct is already chosen and on mclk.
*/
`default_nettype none
module dpw_channel (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  // Configuration and time base
  input  wire dpw_pkg::dpw_chan_cfg_type cfg,
  input  wire dpw_pkg::dpw_tmr_type      tmr,
  input  wire logic [1:0]                clk_phase,
  // Output
  output logic                           pwm_out
);
  logic [9:0] duty_r;
  logic       active_r;
  logic [1:0] low_bits;
  logic [9:0] time_base;
  logic       reload;
  logic       reach;

  // Two low bits: clock phase at prescale 1, else prescaler bits
  assign low_bits  = (tmr.prescale == dpw_pkg::PRE_1)  ? clk_phase :
                     (tmr.prescale == dpw_pkg::PRE_4)  ? tmr.pre_cnt[1:0] :
                                                          tmr.pre_cnt[3:2];
  assign time_base = {tmr.count, low_bits};
  assign reload    = tmr.inc & tmr.match;
  assign reach     = (time_base >= duty_r);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      duty_r   <= dpw_pkg::DUTY_RST;
      active_r <= 1'b0;
    end else if (reload) begin
      duty_r   <= cfg.duty;
      active_r <= (cfg.duty != dpw_pkg::DUTY_RST);
    end else if (reach) begin
      active_r <= 1'b0;
    end
  end

  // Disabled channel sits at the idle level set by polarity
  assign pwm_out = (cfg.enable & active_r) ^ cfg.polarity;
endmodule
`default_nettype wire

// ---- dv/dpw_monitor.sv ----
/* Checker bound to dpw_top: register read-back and output timing.
   Assumes one mclk domain and the register map of dpw_pkg. */
`default_nettype none
module dpw_mon (
  // Clock, reset and register port
  input wire logic                 mclk,
  input wire logic                 rstn,
  input wire logic [2:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  // Timers and outputs
  input wire dpw_pkg::dpw_tmr_type tmr_two,
  input wire dpw_pkg::dpw_tmr_type tmr_four,
  input wire dpw_pkg::dpw_tmr_type tmr_six,
  input wire logic                 chan_a_out,
  input wire logic                 chan_b_out
);
  localparam logic [7:0] MSK [8] = '{8'h0F, 8'h90, 8'hFF, 8'hC0, 8'h90, 8'hFF, 8'hC0, 8'h00};
  logic [7:0]           sh_r [8];
  logic [7:0]           rx_r, rm_r;
  logic [9:0]           da_r, db_r;
  dpw_pkg::dpw_tmr_type sa, sb;
  // Code 00 reads as a frozen timer
  assign sa = sh_r[0][1:0] == 2'h1 ? tmr_two : sh_r[0][1:0] == 2'h2 ? tmr_four :
    sh_r[0][1:0] == 2'h3 ? tmr_six : '0;
  assign sb = sh_r[0][3:2] == 2'h1 ? tmr_two : sh_r[0][3:2] == 2'h2 ? tmr_four :
    sh_r[0][3:2] == 2'h3 ? tmr_six : '0;
  wire ea = sh_r[1][7], pa = sh_r[1][4], eb = sh_r[4][7], pb = sh_r[4][4];
  wire xa = chan_a_out ^ pa, xb = chan_b_out ^ pb;
  wire la = sa.inc & sa.match, lb = sb.inc & sb.match;
  // Low time-base bits are visible only at prescale 4 and 16
  wire [9:0] ta = {sa.count, sa.prescale == 2'h1 ? sa.pre_cnt[1:0] : sa.pre_cnt[3:2]};
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) begin
      sh_r <= '{0: 8'h05, default: 8'h00};
      {rx_r, rm_r, da_r, db_r} <= '0;
    end else begin
      if (reg_wr) sh_r[reg_addr] <= reg_wdata & MSK[reg_addr];
      rx_r <= reg_rd ? sh_r[reg_addr] : 8'h00;
      // Control bit 5 is a live level, so it is left out
      rm_r <= reg_addr == 3'h1 || reg_addr == 3'h4 ? 8'hDF : 8'hFF;
      if (la) da_r <= {sh_r[2], sh_r[3][7:6]};
      if (lb) db_r <= {sh_r[5], sh_r[6][7:6]};
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_read_back: assert property ((reg_rdata & rm_r) == rx_r)
    else $error("read data wrong");
  a_idle_a: assert property (!ea |-> chan_a_out == pa)
    else $error("a not idle");
  a_idle_b: assert property (!eb |-> chan_b_out == pb)
    else $error("b not idle");
  a_rise_a: assert property (ea && $past(ea) && $stable(pa) &&
    xa && !$past(xa) |-> $past(la)) else $error("a rose off reload");
  a_rise_b: assert property (eb && $past(eb) && $stable(pb) &&
    xb && !$past(xb) |-> $past(lb)) else $error("b rose off reload");
  a_reload_a: assert property (ea && $past(ea) && $stable(pa) && $past(la) |->
    xa == (da_r != 10'h000)) else $error("a reload level");
  a_reload_b: assert property (eb && $past(eb) && $stable(pb) && $past(lb) |->
    xb == (db_r != 10'h000)) else $error("b reload level");
  a_reach_a: assert property (ea && $stable(pa) &&
    $past(ea && xa && !la && sa.prescale != 2'h0 && ta >= da_r) |-> !xa)
    else $error("a held past duty");
endmodule
bind dpw_top dpw_mon u_dpw_mon (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tmr_two(tmr_two), .tmr_four(tmr_four), .tmr_six(tmr_six),
  .chan_a_out(chan_a_out), .chan_b_out(chan_b_out));
`default_nettype wire

// ---- dv/dpw_tmr_model.sv ----
/* Behavioural period timer feeding the PWM time base.
   Assumes one step per four clocks times the prescale factor. */
`default_nettype none
module dpw_tmr_model (
  // Clock and settings
  input  wire logic                mclk,
  input  wire logic                rstn,
  input  wire logic [7:0]          per,
  input  wire logic [1:0]          pre,
  // Timer view
  output var dpw_pkg::dpw_tmr_type tmr
);
  logic [7:0] cnt_r;
  logic [5:0] div_r;
  wire stp = div_r == (pre == dpw_pkg::PRE_16 ? 6'h3F :
    pre == dpw_pkg::PRE_4 ? 6'h0F : 6'h03);
  assign tmr = {cnt_r, stp, cnt_r == per, pre, div_r[5:2]};
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) begin
      cnt_r <= 8'h00;
      div_r <= 6'h00;
    end else begin
      div_r <= stp ? 6'h00 : div_r + 6'h01;
      if (stp) cnt_r <= cnt_r == per ? 8'h00 : cnt_r + 8'h01;
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
/* Self-checking bench for dpw_top with three period timer models.
   Assumes the register indices and timer codes of dpw_pkg. */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MSK [8] = '{8'h0F, 8'h90, 8'hFF, 8'hC0, 8'h90, 8'hFF, 8'hC0, 8'h00};
  logic                 mclk, rstn, reg_wr, reg_rd, a_out, b_out;
  logic [2:0]           reg_addr, ad;
  logic [7:0]           reg_wdata, reg_rdata, rv, d;
  logic [9:0]           da;
  logic [7:0]           per [3] = '{8'h1F, 8'h3F, 8'hFF};
  logic [1:0]           pre [3] = '{dpw_pkg::PRE_1, dpw_pkg::PRE_16, dpw_pkg::PRE_4};
  dpw_pkg::dpw_tmr_type tm [3];
  int                   n_fail, total_checks, seed, cyc, zc;
  dpw_top u_dpw_top (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr_two(tm[0]),
    .tmr_four(tm[1]), .tmr_six(tm[2]), .chan_a_out(a_out), .chan_b_out(b_out));
  for (genvar i = 0; i < 3; i++) begin : g_tmr
    dpw_tmr_model u_dpw_tmr_model (.mclk(mclk), .rstn(rstn), .per(per[i]), .pre(pre[i]),
      .tmr(tm[i]));
  end
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // The first rise may carry stale settings, so the next full period is timed
  task automatic meas(input logic ch, input int t, input int dv);
    int f, p = 0, hi = 0, n = 0, g = 0;
    logic x, l = 1'b0;
    f = pre[t] == dpw_pkg::PRE_1 ? 1 : pre[t] == dpw_pkg::PRE_4 ? 4 : 16;
    while (n < 3 && g < 40000) begin
      @(posedge mclk);
      #1 x = ch ? ~b_out : a_out;
      g++;
      n += x && !l;
      hi += n == 2 && x;
      p += n == 2;
      l = x;
    end
    chk(p, 4 * f * (per[t] + 1));
    chk((hi > dv * f ? hi - dv * f : dv * f - hi) <= f + 3, 1'b1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    seed = 59;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rv);
      chk(rv, a == 0 ? 8'h05 : 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      ad = 3'($random(seed));
      d = 8'($random(seed));
      d[2] = d[2] | ~d[3];
      d[0] = d[0] | ~d[1];
      wr(ad, d);
      rd(ad, rv);
      chk(rv & (ad == 3'h1 || ad == 3'h4 ? 8'hDF : 8'hFF), d & MSK[ad]);
    end
    // Zero duty on a enabled, b disabled; both must rest high
    wr(3'h0, 8'h05);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h10);
    wr(3'h1, 8'h90);
    repeat (140) @(posedge mclk);
    zc = 0;
    repeat (300) begin
      @(posedge mclk);
      #1 zc += (a_out !== 1'b1) + (b_out !== 1'b1);
    end
    chk(zc, 0);
    rd(3'h1, rv);
    chk(rv, 8'hB0);
    for (int c = 1; c < 4; c++) begin
      da = 10'($unsigned($random(seed)) % (2 * (per[c - 1] + 1)) + 1);
      wr(3'h0, {4'h0, 2'(4 - c), 2'(c)});
      wr(3'h2, da[9:2]);
      wr(3'h3, {da[1:0], 6'h00});
      wr(3'h5, 8'h00);
      wr(3'h6, 8'h40);
      wr(3'h1, 8'h80);
      wr(3'h4, 8'h90);
      meas(1'b0, c - 1, da);
      meas(1'b1, 3 - c, 1);
    end
    conclude();
  end
endmodule
`default_nettype wire
